//--- inc/nhrh_pkg.sv
// Shared constants and carrier types for the host reply handshake block
package nhrh_pkg;

    // ========================================================================
    // Bus geometry
    localparam int          NHRH_IDX_W      = 16;
    localparam int          NHRH_ADR_W      = 18;
    localparam int          NHRH_DAT_W      = 32;

    // ========================================================================
    // Register indices, byte address is four times the index
    localparam logic [15:0] NHRH_IDX_CSW    = 16'hFFDA;
    localparam logic [15:0] NHRH_IDX_IRQST  = 16'hFFE0;
    localparam logic [15:0] NHRH_IDX_IRQMSK = 16'hFFE2;
    localparam logic [15:0] NHRH_IDX_BLEN   = 16'hFFE8;
    localparam logic [15:0] NHRH_IDX_REPLY  = 16'hFFEA;
    localparam logic [15:0] NHRH_IDX_FID    = 16'hFFEC;

    // ========================================================================
    // Reply control field positions
    localparam int          NHRH_REPLY_W    = 4;
    localparam int          NHRH_BIT_SERV   = 0;
    localparam int          NHRH_BIT_EXIST  = 1;
    localparam int          NHRH_BIT_CUSTOM = 2;
    localparam int          NHRH_BIT_EXTRA  = 3;

    // ========================================================================
    // Interrupt status and mask layout
    localparam int          NHRH_IRQ_W      = 2;
    localparam int          NHRH_IRQ_GEN    = 0;
    localparam int          NHRH_IRQ_PREF   = 1;

    // ========================================================================
    // Reset values and default status words
    localparam logic [15:0] NHRH_RST_REG    = 16'h0000;
    localparam logic [15:0] NHRH_SW_OK      = 16'h9000;
    localparam logic [15:0] NHRH_SW_NOFILE  = 16'h6A82;

    typedef enum logic [1:0] {
        NHRH_CMD_SELECT,
        NHRH_CMD_READ,
        NHRH_CMD_UPDATE
    } nhrh_cmd_e;

    // Request handed in by the reader-facing engine
    typedef struct packed {
        nhrh_cmd_e   cmd;
        logic [15:0] fid;
        logic [15:0] len;
    } nhrh_req_s;

    // Answer handed back to the reader-facing engine
    typedef struct packed {
        logic [15:0] sw;
        logic        file_found;
    } nhrh_rsp_s;

    // One register access decoded from the bus
    typedef struct packed {
        logic        wr;
        logic [1:0]  be;
        logic [15:0] idx;
        logic [15:0] wdat;
    } nhrh_acc_s;

endpackage

//--- src/nhrh_host_reply.sv
// Host reply handshake register bank of a dynamic type 4 tag
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module nhrh_host_reply
    import nhrh_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [NHRH_ADR_W-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [NHRH_DAT_W-1:0] dat_i,
    output logic                       ack_o,
    output logic [NHRH_DAT_W-1:0]      dat_o,
    // Reader-facing engine
    input  wire logic                  req_valid_i,
    input  wire nhrh_req_s             req_i,
    output logic                       req_ready_o,
    input  wire logic                  prefetch_i,
    output logic                       rsp_valid_o,
    output nhrh_rsp_s                  rsp_o,
    output logic                       buf_grow_o,
    // Interrupt
    output logic                       irq_o
);
    typedef enum logic {
        NHRH_ST_IDLE,
        NHRH_ST_WAIT_HOST
    } nhrh_state_e;

    typedef struct packed {
        nhrh_state_e             fsm;
        logic [NHRH_REPLY_W-1:0] reply;
        logic [15:0]             blen;
        logic [15:0]             fid;
        logic [15:0]             csw;
        logic [NHRH_IRQ_W-1:0]   mask;
        nhrh_cmd_e               cmd;
        logic                    pf_armed;
        logic                    pf_pending;
        logic                    ready;
        logic                    rsp_valid;
        nhrh_rsp_s               rsp;
        logic                    grow;
    } nhrh_main_s;

    nhrh_main_s            s;
    nhrh_main_s            next_s;
    nhrh_acc_s             acc;
    logic [15:0]           rdata;
    logic [NHRH_IRQ_W-1:0] irq_set;
    logic [NHRH_IRQ_W-1:0] irq_clr;
    logic [NHRH_IRQ_W-1:0] irq_stat;
    logic                  req_take;
    logic                  pf_take;
    logic                  serve;

    // ========================================================================
    // Bus front end and interrupt flags
    nhrh_wb_front u_front (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .cyc_i   (cyc_i),
        .stb_i   (stb_i),
        .we_i    (we_i),
        .adr_i   (adr_i),
        .sel_i   (sel_i),
        .dat_i   (dat_i),
        .rdata_i (rdata),
        .ack_o   (ack_o),
        .dat_o   (dat_o),
        .acc_o   (acc)
    );

    nhrh_irq #(
        .W (NHRH_IRQ_W)
    ) u_irq (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (irq_set),
        .clr_i  (irq_clr),
        .mask_i (s.mask),
        .stat_o (irq_stat),
        .irq_o  (irq_o)
    );

    // ========================================================================
    // Read data mux; unmapped indices read zero
    always_comb begin
        rdata = 16'h0000;
        case (acc.idx)
            NHRH_IDX_CSW:    rdata = s.csw;
            NHRH_IDX_IRQST:  rdata = {14'h0000, irq_stat};
            NHRH_IDX_IRQMSK: rdata = {14'h0000, s.mask};
            NHRH_IDX_BLEN:   rdata = s.blen;
            NHRH_IDX_REPLY:  rdata = {12'h000, s.reply};
            NHRH_IDX_FID:    rdata = s.fid;
            default:         rdata = 16'h0000;
        endcase
    end

    // ========================================================================
    // Event qualification
    always_comb begin
        req_take = req_valid_i && s.ready;
        // Prefetch counts only after a read answer, with its enable set; a new request cancels it
        pf_take  = prefetch_i && s.pf_armed && s.mask[NHRH_IRQ_PREF] && !req_take;
        // Reply fields are looked at only once serviced reads one
        serve    = (s.fsm == NHRH_ST_WAIT_HOST) && s.reply[NHRH_BIT_SERV];
        irq_set  = '0;
        irq_set[NHRH_IRQ_GEN]  = req_take;
        irq_set[NHRH_IRQ_PREF] = pf_take;
        irq_clr  = (acc.wr && acc.be[0] && acc.idx == NHRH_IDX_IRQST)
                   ? acc.wdat[NHRH_IRQ_W-1:0] : '0;
    end

    // ========================================================================
    // Next state: hardware actions first, software writes last
    always_comb begin
        next_s           = s;
        next_s.rsp_valid = 1'b0;
        next_s.grow      = 1'b0;

        unique case (s.fsm)
            NHRH_ST_IDLE: begin
                if (req_take) begin
                    // Capture the request and hand it to the host
                    next_s.cmd      = req_i.cmd;
                    next_s.fid      = req_i.fid;
                    next_s.blen     = req_i.len;
                    next_s.reply[NHRH_BIT_SERV] = 1'b0;
                    next_s.pf_armed = 1'b0;
                    next_s.ready    = 1'b0;
                    next_s.fsm      = NHRH_ST_WAIT_HOST;
                end else if (pf_take) begin
                    // Host now decides on extra data for the running read
                    next_s.reply[NHRH_BIT_SERV] = 1'b0;
                    next_s.pf_armed   = 1'b0;
                    next_s.pf_pending = 1'b1;
                    next_s.ready      = 1'b0;
                    next_s.fsm        = NHRH_ST_WAIT_HOST;
                end
            end
            NHRH_ST_WAIT_HOST: begin
                if (serve) begin
                    next_s.reply[NHRH_BIT_SERV] = 1'b0;
                    next_s.ready = 1'b1;
                    next_s.fsm   = NHRH_ST_IDLE;
                    if (s.pf_pending) begin
                        // Extra data means the buffer grew during transmission
                        next_s.grow       = s.reply[NHRH_BIT_EXTRA];
                        next_s.pf_pending = 1'b0;
                    end else begin
                        next_s.rsp_valid      = 1'b1;
                        next_s.rsp.file_found = s.reply[NHRH_BIT_EXIST];
                        if (s.reply[NHRH_BIT_CUSTOM]) begin
                            next_s.rsp.sw = s.csw;
                        end else if (s.cmd == NHRH_CMD_SELECT && !s.reply[NHRH_BIT_EXIST]) begin
                            next_s.rsp.sw = NHRH_SW_NOFILE;
                        end else begin
                            next_s.rsp.sw = NHRH_SW_OK;
                        end
                        // Only a read answer can be followed by a prefetch
                        next_s.pf_armed = (s.cmd == NHRH_CMD_READ);
                    end
                end
            end
        endcase

        // Software writes land last so a set of serviced beats the hardware clear
        if (acc.wr) begin
            case (acc.idx)
                NHRH_IDX_REPLY: begin
                    if (acc.be[0]) begin
                        next_s.reply = acc.wdat[NHRH_REPLY_W-1:0];
                    end
                end
                NHRH_IDX_BLEN: begin
                    if (acc.be[0]) begin
                        next_s.blen[7:0] = acc.wdat[7:0];
                    end
                    if (acc.be[1]) begin
                        next_s.blen[15:8] = acc.wdat[15:8];
                    end
                end
                NHRH_IDX_FID: begin
                    if (acc.be[0]) begin
                        next_s.fid[7:0] = acc.wdat[7:0];
                    end
                    if (acc.be[1]) begin
                        next_s.fid[15:8] = acc.wdat[15:8];
                    end
                end
                NHRH_IDX_CSW: begin
                    if (acc.be[0]) begin
                        next_s.csw[7:0] = acc.wdat[7:0];
                    end
                    if (acc.be[1]) begin
                        next_s.csw[15:8] = acc.wdat[15:8];
                    end
                end
                NHRH_IDX_IRQMSK: begin
                    if (acc.be[0]) begin
                        next_s.mask = acc.wdat[NHRH_IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s       <= '0;
            s.blen  <= NHRH_RST_REG;
            s.fid   <= NHRH_RST_REG;
            s.csw   <= NHRH_RST_REG;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign req_ready_o = s.ready;
    assign rsp_valid_o = s.rsp_valid;
    assign rsp_o       = s.rsp;
    assign buf_grow_o  = s.grow;

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    serviced_gate_a: assert property (
        s.fsm == NHRH_ST_WAIT_HOST && !s.reply[NHRH_BIT_SERV] && !acc.wr
        |=> !rsp_valid_o && !buf_grow_o && s.fsm == NHRH_ST_WAIT_HOST)
        else $error("acted on reply before serviced");

    service_start_a: assert property (
        s.fsm == NHRH_ST_WAIT_HOST && s.reply[NHRH_BIT_SERV] && !s.pf_pending
        |=> rsp_valid_o && req_ready_o ##1 !rsp_valid_o)
        else $error("serviced reply not processed in one cycle");

    custom_word_a: assert property (
        rsp_valid_o && $past(s.reply[NHRH_BIT_CUSTOM]) |-> rsp_o.sw == $past(s.csw))
        else $error("custom status word not returned");

    default_word_a: assert property (
        rsp_valid_o && !$past(s.reply[NHRH_BIT_CUSTOM]) && $past(s.cmd) != NHRH_CMD_SELECT
        |-> rsp_o.sw == NHRH_SW_OK)
        else $error("default status word wrong");

    file_status_a: assert property (
        rsp_valid_o && $past(s.cmd) == NHRH_CMD_SELECT
        |-> rsp_o.file_found == $past(s.reply[NHRH_BIT_EXIST])
            && (rsp_o.file_found || $past(s.reply[NHRH_BIT_CUSTOM]) || rsp_o.sw == NHRH_SW_NOFILE))
        else $error("file status not reported");

    extra_grow_a: assert property (
        serve && s.pf_pending |=> buf_grow_o == $past(s.reply[NHRH_BIT_EXTRA]) && !rsp_valid_o)
        else $error("buffer growth not tied to extra data");

    block_len_a: assert property (
        req_take && !acc.wr |=> s.blen == $past(req_i.len) ##1 !req_ready_o || s.fsm == NHRH_ST_IDLE)
        else $error("block length not captured");
endmodule
`default_nettype wire

//--- src/nhrh_irq.sv
// Sticky event flags with write-one-to-clear and a masked level interrupt
`timescale 1ns/1ns
`default_nettype none
module nhrh_irq
    import nhrh_pkg::*;
#(
    parameter int W = NHRH_IRQ_W
)(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    input  wire logic [W-1:0] mask_i,
    output logic [W-1:0]      stat_o,
    output logic              irq_o
);
    typedef struct packed {
        logic [W-1:0] stat;
        logic         irq;
    } nhrh_irq_s;

    nhrh_irq_s    s;
    nhrh_irq_s    next_s;
    logic [W-1:0] next_bit;

    // ========================================================================
    // Set beats clear so an event in the clearing cycle survives
    for (genvar i = 0; i < W; i++) begin : g_flag
        assign next_bit[i] = set_i[i] || (s.stat[i] && !clr_i[i]);
    end

    always_comb begin
        next_s.stat = next_bit;
        next_s.irq  = |(next_bit & mask_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign stat_o = s.stat;
    assign irq_o  = s.irq;
endmodule
`default_nettype wire

//--- src/nhrh_wb_front.sv
// Classic Wishbone slave front end for the reply handshake registers
`timescale 1ns/1ns
`default_nettype none
module nhrh_wb_front
    import nhrh_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [NHRH_ADR_W-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [NHRH_DAT_W-1:0] dat_i,
    input  wire logic [15:0]           rdata_i,
    output logic                       ack_o,
    output logic [NHRH_DAT_W-1:0]      dat_o,
    output nhrh_acc_s                  acc_o
);
    typedef struct packed {
        logic                  ack;
        logic [NHRH_DAT_W-1:0] dat;
    } nhrh_front_s;

    nhrh_front_s s;
    nhrh_front_s next_s;
    logic        take;

    // ========================================================================
    // Decode, one access per request; ack gating keeps a held request single
    always_comb begin
        take         = cyc_i && stb_i && !s.ack;
        acc_o.wr     = take && we_i;
        acc_o.be     = sel_i[1:0];
        acc_o.idx    = adr_i[NHRH_ADR_W-1:2];
        acc_o.wdat   = dat_i[15:0];
        next_s.ack   = take;
        next_s.dat   = take ? {16'h0000, rdata_i} : s.dat;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ack_o = s.ack;
    assign dat_o = s.dat;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    bus_ack_once_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle after request");
endmodule
`default_nettype wire

//--- test/nhrh_host_model.sv
// Host controller model driving the reply registers over classic Wishbone
`timescale 1ns/1ns
`default_nettype none
module nhrh_host_model
    import nhrh_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  ack_i,
    input  wire logic [NHRH_DAT_W-1:0] dat_i,
    output var logic                   cyc_o,
    output var logic                   stb_o,
    output var logic                   we_o,
    output var logic [NHRH_ADR_W-1:0]  adr_o,
    output var logic [3:0]             sel_o,
    output var logic [NHRH_DAT_W-1:0]  dat_o
);
    // ========================================================================
    // Idle bus at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = '0;
        sel_o = 4'h0;
        dat_o = 32'h5A5A_A5A5;
    end

    // ========================================================================
    // One classic cycle; waits for ack however long it takes
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [3:0] be,
                        input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= be;
        dat_o <= {16'h0000, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i[15:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        dat_o <= ~dat_o; // Released data must never look like the last write
    endtask

    // ========================================================================
    // Service one interrupt: identify the file, clear the flag, then reply
    task automatic answer(input logic [1:0] flag, input logic [3:0] bits, output logic [15:0] fid);
        logic [15:0] q;
        xfer(1'b0, NHRH_IDX_FID, 4'h3, 16'h0000, fid);
        xfer(1'b1, NHRH_IDX_IRQST, 4'h3, {14'h0000, flag}, q);
        // Extra data only ever claimed when answering a prefetch flag
        xfer(1'b1, NHRH_IDX_REPLY, 4'h3, {12'h000, bits & {flag[1], 3'b111}}, q);
    endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the host reply handshake register bank
`timescale 1ns/1ns
`default_nettype none
module testbench
    import nhrh_pkg::*;
();
    logic                  clk_i;
    logic                  rst_i;
    logic                  wb_cyc;
    logic                  wb_stb;
    logic                  wb_we;
    logic [NHRH_ADR_W-1:0] wb_adr;
    logic [3:0]            wb_sel;
    logic [NHRH_DAT_W-1:0] wb_wdat;
    logic                  wb_ack;
    logic [NHRH_DAT_W-1:0] wb_rdat;
    logic                  req_valid;
    nhrh_req_s             req;
    logic                  req_ready;
    logic                  prefetch;
    logic                  rsp_valid;
    nhrh_rsp_s             rsp;
    nhrh_rsp_s             rsp_cap;
    logic                  buf_grow;
    logic                  irq;
    int                    fail_count = 0;
    int                    num_checks = 0;
    int                    rsp_cnt    = 0;
    int                    grow_cnt   = 0;
    integer                seed       = 32'hA9948686;

    // ========================================================================
    // Clock and instances
    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;

    nhrh_host_reply u_nhrh_host_reply (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(wb_cyc), .stb_i(wb_stb), .we_i(wb_we), .adr_i(wb_adr),
        .sel_i(wb_sel), .dat_i(wb_wdat), .ack_o(wb_ack), .dat_o(wb_rdat), .req_valid_i(req_valid),
        .req_i(req), .req_ready_o(req_ready), .prefetch_i(prefetch), .rsp_valid_o(rsp_valid),
        .rsp_o(rsp), .buf_grow_o(buf_grow), .irq_o(irq)
    );

    nhrh_host_model u_nhrh_host_model (
        .clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_rdat), .cyc_o(wb_cyc), .stb_o(wb_stb),
        .we_o(wb_we), .adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_wdat)
    );

    // Pulses stand one cycle, so count them at every edge
    always @(posedge clk_i) begin
        if (rsp_valid === 1'b1) begin
            rsp_cnt = rsp_cnt + 1;
            rsp_cap = rsp;
        end
        if (buf_grow === 1'b1) begin
            grow_cnt = grow_cnt + 1;
        end
    end

    // ========================================================================
    // Comparisons, bus helpers and expectations
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_val({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [15:0] q;
        u_nhrh_host_model.xfer(1'b1, idx, 4'h3, d, q);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] exp, input string what);
        logic [15:0] q;
        u_nhrh_host_model.xfer(1'b0, idx, 4'h3, 16'h0000, q);
        chk_val(q, exp, what);
    endtask

    function automatic logic [15:0] exp_sw(input nhrh_cmd_e c, input logic [3:0] b, input logic [15:0] cw);
        if (b[NHRH_BIT_CUSTOM]) return cw;
        if (c == NHRH_CMD_SELECT && !b[NHRH_BIT_EXIST]) return NHRH_SW_NOFILE;
        return NHRH_SW_OK;
    endfunction

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs about a thousand cycles
    initial begin
        #(30000 * 10);
        fail_count = fail_count + 1;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    // ========================================================================
    // Main sequence
    initial begin
        logic [15:0] q, d, fid, len, cw;
        logic [3:0]  bits;
        logic [1:0]  msk;
        logic        extra;
        nhrh_cmd_e   cmd;
        int          rbase, gbase;
        rst_i     = 1'b1;
        req_valid = 1'b0;
        req       = '0;
        prefetch  = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(NHRH_IDX_REPLY, 16'h0000, "reply reset");
        rd(NHRH_IDX_BLEN, 16'h0000, "length reset");
        chk_bit(req_ready, 1'b1, "ready after reset");
        // Byte lanes: lane 1 is the upper address byte
        d = 16'($random(seed));
        u_nhrh_host_model.xfer(1'b1, NHRH_IDX_BLEN, 4'h2, d, q);
        rd(NHRH_IDX_BLEN, {d[15:8], 8'h00}, "length high lane");
        u_nhrh_host_model.xfer(1'b1, NHRH_IDX_BLEN, 4'h1, d, q);
        rd(NHRH_IDX_BLEN, d, "length both lanes");
        wr(16'h0100, d);
        rd(16'h0100, 16'h0000, "unmapped index");
        // Random requests; cmd cycles through every command
        for (int i = 0; i < 24; i++) begin
            cmd  = nhrh_cmd_e'(i % 3);
            fid  = 16'($random(seed));
            len  = 16'($random(seed));
            cw   = 16'($random(seed));
            bits = {1'b0, 2'($random(seed)), 1'b0};
            msk  = 2'($random(seed));
            wr(NHRH_IDX_IRQMSK, {14'h0000, msk});
            wr(NHRH_IDX_CSW, cw);
            @(posedge clk_i);
            req_valid <= 1'b1;
            req       <= '{cmd, fid, len};
            @(posedge clk_i);
            req_valid <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk_bit(req_ready, 1'b0, "ready while open");
            chk_bit(irq, msk[0], "irq follows mask");
            rd(NHRH_IDX_BLEN, len, "block length");
            // Reply fields without serviced must be left alone
            rbase = rsp_cnt;
            wr(NHRH_IDX_REPLY, {12'h000, bits});
            repeat (4) @(posedge clk_i);
            chk_val(16'(rsp_cnt - rbase), 16'h0000, "early answer");
            u_nhrh_host_model.answer(2'b01, bits | 4'h1, q);
            chk_val(q, fid, "file identifier");
            repeat (4) @(posedge clk_i);
            chk_val(16'(rsp_cnt - rbase), 16'h0001, "one answer");
            chk_val(rsp_cap.sw, exp_sw(cmd, bits, cw), "status word");
            chk_bit(rsp_cap.file_found, bits[1], "file found");
            chk_bit(req_ready, 1'b1, "ready after answer");
            chk_bit(irq, 1'b0, "irq after clear");
            rd(NHRH_IDX_REPLY, {12'h000, bits}, "serviced cleared");
            if (cmd == NHRH_CMD_READ) begin
                rbase = rsp_cnt;
                gbase = grow_cnt;
                extra = 1'($random(seed));
                @(posedge clk_i);
                prefetch <= 1'b1;
                @(posedge clk_i);
                prefetch <= 1'b0;
                repeat (2) @(posedge clk_i);
                chk_bit(irq, msk[1], "irq on prefetch");
                rd(NHRH_IDX_IRQST, {14'h0000, msk[1], 1'b0}, "prefetch flag");
                if (msk[1]) begin
                    u_nhrh_host_model.answer(2'b10, {extra, 3'b001}, q);
                end
                repeat (4) @(posedge clk_i);
                chk_val(16'(grow_cnt - gbase), {15'h0000, extra & msk[1]}, "buffer growth");
                chk_val(16'(rsp_cnt - rbase), 16'h0000, "no answer on prefetch");
                chk_bit(req_ready, 1'b1, "ready after prefetch");
            end
        end
        // Mid-run reset must bring the length and custom word registers back to zero
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(NHRH_IDX_BLEN, 16'h0000, "length after reset");
        rd(NHRH_IDX_CSW, 16'h0000, "custom word after reset");
        chk_bit(req_ready, 1'b1, "ready after second reset");
        final_report();
    end
endmodule
`default_nettype wire
